// [verilog/scsi_port_pkg.sv]
// Shared constants and types for the adapter host register port
package scsi_port_pkg;
    localparam logic [15:0] ADDR_SETUP = 16'h0d52;
    localparam logic [15:0] ADDR_STACK = 16'h0d58;
    localparam logic [15:0] ADDR_BURST = 16'h0d5b;
    localparam logic [15:0] ADDR_SIDE = 16'h0d5c;
    localparam logic [15:0] ADDR_REPORT = 16'h0d5e;
    localparam logic [15:0] ADDR_REPORT_HI = 16'h0d5f;
    localparam logic [15:0] UNLOCK_VALUE = 16'h0044;
    localparam int STACK_BYTES = 16;
    localparam logic [4:0] MAX_STORED = 5'h10;
    localparam logic [4:0] UNEXPECTED_TAG = 5'h1f;
    localparam logic [4:0] RECOVERY_TAG = 5'h10;
    localparam logic [4:0] LAST_QUEUE_TAG = 5'h0f;
    localparam int ST_BUSY = 7;
    localparam int CFG_DMA_EN = 12;
    localparam int CFG_IRQ_EN = 9;
    localparam int CFG_IRQ_LVL = 8;
    localparam logic [7:0] CFG_WR_MASK = 8'hf3;
    localparam logic [2:0] BURST_MAX_NORMAL = 3'h1;
    localparam logic [7:0] HREG_ADDR = 8'h00;
    localparam logic [7:0] HREG_WDATA = 8'h04;
    localparam logic [7:0] HREG_GO = 8'h08;
    localparam logic [7:0] HREG_RESULT = 8'h0c;
    localparam logic [15:0] STATUS_RESET = 16'h0080;

    typedef enum logic [3:0] {
        OP_SEND_SCSI = 4'h0,
        OP_BUFFER_RW = 4'h1,
        OP_RSVD2 = 4'h2,
        OP_RSVD3 = 4'h3,
        OP_SELF_TEST = 4'h4,
        OP_WRAP_TEST = 4'h5,
        OP_CLEAR_TAG = 4'h6,
        OP_CONTINUE = 4'h7,
        OP_ADAPTER_INFO = 4'h8,
        OP_BUS_RESET = 4'h9
    } opcode_t;

    // True for codes the adapter does not act on
    function automatic logic op_reserved(input logic [3:0] op);
        op_reserved = (op == OP_RSVD2) || (op == OP_RSVD3) || (op > OP_BUS_RESET);
    endfunction

    // Codes that may only use the sixteen queue tags
    function automatic logic op_queued(input logic [3:0] op);
        op_queued = (op == OP_SEND_SCSI) || (op == OP_BUFFER_RW);
    endfunction
endpackage

// [verilog/scsi_io_if.sv]
// I/O channel between host processor and adapter register port
`timescale 1ns/1ps
interface scsi_io_if;
    logic [15:0] io_addr;
    logic [15:0] io_wdata;
    logic io_wr;
    logic io_rd;
    logic io_word;
    logic [15:0] io_rdata;
    logic irq_l11;
    logic irq_l12;
    logic dma_req;
    logic [2:0] dma_chan;

    modport dev (
        input io_addr, io_wdata, io_wr, io_rd, io_word,
        output io_rdata, irq_l11, irq_l12, dma_req, dma_chan
    );
    modport host (
        output io_addr, io_wdata, io_wr, io_rd, io_word,
        input io_rdata, irq_l11, irq_l12, dma_req, dma_chan
    );
endinterface

// [verilog/scsi_port_dev.sv]
// Adapter end of the host register port: registers, queue handshake, interrupt
`timescale 1ns/1ps
module scsi_port_dev
    import scsi_port_pkg::*;
#(
    parameter logic [3:0] EC_LEVEL = 4'hf
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    scsi_io_if.dev io,
    output logic init_start_out,
    output logic cmd_valid_out,
    output logic [3:0] cmd_op_out,
    output logic cmd_reserved_out,
    output logic [3:0] cmd_count_out,
    output logic [4:0] cmd_tag_out,
    output logic [127:0] cmd_stack_out,
    output logic [2:0] burst_code_out,
    input wire logic done_in,
    input wire logic done_scsi_in,
    input wire logic [7:0] done_code_in,
    input wire logic [4:0] done_tag_in,
    input wire logic [15:0] done_ext_in,
    input wire logic done_aux_we_in,
    input wire logic [15:0] done_aux_in,
    input wire logic dma_want_in
);
    typedef struct packed {
        logic locked;
        logic init_wait;
        logic init_hold;
        logic busy;
        logic valid;
        logic stype;
        logic [4:0] tag;
        logic [7:0] code;
        logic [15:0] ext;
        logic [15:0] aux;
        logic [7:0] cfg_hi;
        logic [2:0] burst;
        logic [3:0] ptr;
        logic [STACK_BYTES-1:0][7:0] stack;
        logic pend;
        logic [4:0] stored;
        logic irq_pend;
        logic [15:0] rdata;
        logic irq11;
        logic irq12;
        logic dma_req;
        logic init_start;
        logic cmd_valid;
        logic [3:0] cmd_op;
        logic cmd_reserved;
        logic [3:0] cmd_count;
        logic [4:0] cmd_tag;
        logic [STACK_BYTES-1:0][7:0] cmd_stack;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;

    logic [7:0] low_status;
    logic [2:0] chan;
    logic chan_ok;

    assign low_status = {q.busy, q.valid, q.stype, q.tag};

    always_comb begin
        d = q;
        d.rdata = 16'h0000;
        d.init_start = 1'b0;
        d.cmd_valid = 1'b0;
        if (io.io_rd) begin
            case (io.io_addr)
                ADDR_REPORT: begin
                    if (io.io_word) begin
                        d.rdata = {q.code, low_status};
                    end else begin
                        d.rdata = {8'h00, low_status};
                        d.irq_pend = 1'b0;
                        d.valid = 1'b0;
                    end
                    if (q.init_hold) begin
                        d.init_hold = 1'b0;
                        d.busy = 1'b0;
                    end
                end
                ADDR_REPORT_HI: d.rdata = {8'h00, q.code};
                ADDR_STACK: d.rdata = q.ext;
                ADDR_SIDE: d.rdata = q.aux;
                ADDR_SETUP: begin
                    if (io.io_word) begin
                        d.rdata = {q.cfg_hi, 4'h0, EC_LEVEL};
                    end
                end
                default: d.rdata = 16'h0000;
            endcase
        end
        if (io.io_wr) begin
            case (io.io_addr)
                ADDR_SIDE: begin
                    if (io.io_word) begin
                        d.aux = io.io_wdata;
                        if (q.locked && io.io_wdata == UNLOCK_VALUE) begin
                            d.locked = 1'b0;
                            d.init_wait = 1'b1;
                            d.init_start = 1'b1;
                        end
                    end
                end
                ADDR_REPORT: begin
                    // Byte-wide command writes are undefined and dropped
                    if (io.io_word && !q.locked) begin
                        d.busy = 1'b1;
                        d.pend = 1'b1;
                        d.cmd_op = io.io_wdata[15:12];
                        d.cmd_reserved = op_reserved(io.io_wdata[15:12]);
                        d.cmd_count = io.io_wdata[11:8];
                        d.cmd_tag = io.io_wdata[4:0];
                        d.cmd_stack = q.stack;
                        d.ptr = 4'h0;
                    end
                end
                ADDR_STACK: begin
                    if (io.io_word) begin
                        d.stack[q.ptr] = io.io_wdata[15:8];
                        d.stack[q.ptr + 4'h1] = io.io_wdata[7:0];
                        d.ptr = q.ptr + 4'h2;
                    end
                end
                ADDR_BURST: d.burst = io.io_wdata[3:1];
                ADDR_SETUP: begin
                    if (io.io_word) begin
                        d.cfg_hi = io.io_wdata[15:8] & CFG_WR_MASK;
                    end
                end
                default: d.cfg_hi = d.cfg_hi;
            endcase
        end
        // Queue hand-off; the recovery tag bypasses a full queue
        if (q.pend && !q.init_wait && !q.init_hold) begin
            if (q.stored < MAX_STORED || q.cmd_tag == RECOVERY_TAG) begin
                d.pend = 1'b0;
                d.busy = 1'b0;
                d.cmd_valid = 1'b1;
                if (q.cmd_tag != RECOVERY_TAG) begin
                    d.stored = q.stored + 5'h01;
                end
            end
        end
        // Completion is applied last so a report wins over a same-cycle read
        if (done_in) begin
            d.code = done_code_in;
            d.stype = done_scsi_in;
            d.tag = done_tag_in;
            d.ext = done_ext_in;
            d.valid = 1'b1;
            d.irq_pend = 1'b1;
            if (q.init_wait) begin
                d.init_wait = 1'b0;
                d.init_hold = 1'b1;
                d.cfg_hi = 8'h00;
            end else if (done_tag_in != UNEXPECTED_TAG && done_tag_in != RECOVERY_TAG && q.stored != 5'h00) begin
                d.stored = d.stored - 5'h01;
            end
        end
        if (done_aux_we_in) begin
            d.aux = done_aux_in;
        end
        d.irq11 = d.irq_pend && d.cfg_hi[CFG_IRQ_EN-8] && !d.cfg_hi[CFG_IRQ_LVL-8];
        d.irq12 = d.irq_pend && d.cfg_hi[CFG_IRQ_EN-8] && d.cfg_hi[CFG_IRQ_LVL-8];
        // Request follows the new setup so it never shows beside a stale channel
        chan = d.cfg_hi[7:5];
        chan_ok = (chan != 3'h2) && (chan != 3'h4);
        d.dma_req = dma_want_in && d.cfg_hi[CFG_DMA_EN-8] && chan_ok;
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q <= '0;
            q.locked <= 1'b1;
            q.busy <= STATUS_RESET[ST_BUSY];
        end else begin
            q <= d;
        end
    end

    assign io.io_rdata = q.rdata;
    assign io.irq_l11 = q.irq11;
    assign io.irq_l12 = q.irq12;
    assign io.dma_req = q.dma_req;
    assign io.dma_chan = q.cfg_hi[7:5];
    assign init_start_out = q.init_start;
    assign cmd_valid_out = q.cmd_valid;
    assign cmd_op_out = q.cmd_op;
    assign cmd_reserved_out = q.cmd_reserved;
    assign cmd_count_out = q.cmd_count;
    assign cmd_tag_out = q.cmd_tag;
    assign cmd_stack_out = q.cmd_stack;
    assign burst_code_out = q.burst;
endmodule

// [verilog/scsi_port_host.sv]
// Host processor end of the register port: guarded access sequencer
`timescale 1ns/1ps
module scsi_port_host
    import scsi_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    scsi_io_if.host io,
    input wire logic [7:0] sw_addr_in,
    input wire logic [31:0] sw_wdata_in,
    input wire logic sw_wr_in,
    input wire logic sw_rd_in,
    output logic [31:0] sw_rdata_out,
    output logic irq_seen_out,
    output logic dma_req_out
);
    typedef enum logic [3:0] {
        H_UNLOCK = 4'h0,
        H_IDLE = 4'h1,
        H_POLL_A = 4'h2,
        H_POLL_B = 4'h3,
        H_ACC_A = 4'h4,
        H_ACC_B = 4'h5,
        H_ACK_A = 4'h6,
        H_ACK_B = 4'h7,
        H_ACK_C = 4'h8
    } host_fsm_t;

    typedef struct packed {
        host_fsm_t state;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic go;
        logic go_wr;
        logic go_word;
        logic err;
        logic [15:0] result;
        logic [15:0] io_addr;
        logic [15:0] io_wdata;
        logic io_wr;
        logic io_rd;
        logic io_word;
        logic [31:0] sw_rdata;
        logic irq_seen;
        logic dma_req;
    } host_state_t;

    host_state_t q;
    host_state_t d;
    logic guarded;
    logic tag_bad;

    assign guarded = q.go_wr && (q.addr == ADDR_REPORT || q.addr == ADDR_STACK);
    assign tag_bad = q.go_wr && q.addr == ADDR_REPORT &&
        (op_queued(q.wdata[15:12]) ? (q.wdata[4:0] > LAST_QUEUE_TAG) : (q.wdata[4:0] > RECOVERY_TAG));

    always_comb begin
        d = q;
        d.io_wr = 1'b0;
        d.io_rd = 1'b0;
        d.sw_rdata = 32'h0000_0000;
        d.dma_req = io.dma_req;
        if (sw_rd_in) begin
            case (sw_addr_in)
                HREG_ADDR: d.sw_rdata = {16'h0000, q.addr};
                HREG_WDATA: d.sw_rdata = {16'h0000, q.wdata};
                HREG_RESULT: d.sw_rdata = {14'h0000, q.err, (q.state != H_IDLE) || q.go, q.result};
                default: d.sw_rdata = 32'h0000_0000;
            endcase
        end
        if (sw_wr_in && q.state == H_IDLE && !q.go) begin
            case (sw_addr_in)
                HREG_ADDR: d.addr = sw_wdata_in[15:0];
                HREG_WDATA: d.wdata = sw_wdata_in[15:0];
                HREG_GO: begin
                    d.go = sw_wdata_in[0] || sw_wdata_in[1];
                    d.go_wr = sw_wdata_in[0];
                    d.go_word = sw_wdata_in[2];
                    d.err = 1'b0;
                end
                default: d.go = 1'b0;
            endcase
        end
        case (q.state)
            H_UNLOCK: begin
                d.io_wr = 1'b1;
                d.io_word = 1'b1;
                d.io_addr = ADDR_SIDE;
                d.io_wdata = UNLOCK_VALUE;
                d.state = H_IDLE;
            end
            H_IDLE: begin
                if (io.irq_l11 || io.irq_l12) begin
                    d.irq_seen = 1'b1;
                    d.io_rd = 1'b1;
                    d.io_word = 1'b1;
                    d.io_addr = ADDR_REPORT;
                    d.state = H_ACK_A;
                end else if (q.go && tag_bad) begin
                    d.go = 1'b0;
                    d.err = 1'b1;
                end else if (q.go && guarded) begin
                    d.io_rd = 1'b1;
                    d.io_word = 1'b1;
                    d.io_addr = ADDR_REPORT;
                    d.state = H_POLL_A;
                end else if (q.go) begin
                    d.state = H_POLL_B;
                end
            end
            H_POLL_A: d.state = H_POLL_B;
            H_POLL_B: begin
                if (guarded && io.io_rdata[ST_BUSY]) begin
                    d.io_rd = 1'b1;
                    d.io_word = 1'b1;
                    d.io_addr = ADDR_REPORT;
                    d.state = H_POLL_A;
                end else begin
                    d.go = 1'b0;
                    d.io_wr = q.go_wr;
                    d.io_rd = !q.go_wr;
                    d.io_word = q.go_word || (q.go_wr && q.addr == ADDR_STACK);
                    d.io_addr = q.addr;
                    d.io_wdata = q.wdata;
                    if (q.go_wr && q.addr == ADDR_BURST) begin
                        d.io_wdata = {8'h00, 1'b0, 3'h0,
                            (q.wdata[3:1] > BURST_MAX_NORMAL) ? BURST_MAX_NORMAL : q.wdata[3:1], 1'b1};
                    end
                    d.state = q.go_wr ? H_IDLE : H_ACC_A;
                end
            end
            H_ACC_A: d.state = H_ACC_B;
            H_ACC_B: begin
                d.result = io.io_rdata;
                d.state = H_IDLE;
            end
            H_ACK_A: begin
                d.io_rd = 1'b1;
                d.io_word = 1'b0;
                d.io_addr = ADDR_REPORT;
                d.state = H_ACK_B;
            end
            H_ACK_B: begin
                d.result = io.io_rdata;
                d.state = H_ACK_C;
            end
            H_ACK_C: d.state = H_IDLE;
            default: d.state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            q <= '0;
            q.state <= H_UNLOCK;
        end else begin
            q <= d;
        end
    end

    assign io.io_addr = q.io_addr;
    assign io.io_wdata = q.io_wdata;
    assign io.io_wr = q.io_wr;
    assign io.io_rd = q.io_rd;
    assign io.io_word = q.io_word;
    assign sw_rdata_out = q.sw_rdata;
    assign irq_seen_out = q.irq_seen;
    assign dma_req_out = q.dma_req;
endmodule

// [dv/scsi_io_props.sv]
// Concurrent checks on the I/O channel between host and adapter ends
`timescale 1ns/1ps
module scsi_io_props
    import scsi_port_pkg::*;
#(
    parameter logic [3:0] EC_LEVEL = 4'hf
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_word,
    input wire logic [15:0] io_rdata,
    input wire logic irq_l11,
    input wire logic irq_l12,
    input wire logic dma_req,
    input wire logic [2:0] dma_chan
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    logic rd_st_q;
    logic bsy_q;
    logic dma_en_q;
    logic irq_en_q;
    logic irq_lvl_q;
    logic [7:0] lo_q;
    // Mirror of setup bits and of the last busy value the host saw
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rd_st_q <= 1'b0;
            bsy_q <= 1'b1;
            dma_en_q <= 1'b0;
            irq_en_q <= 1'b0;
            irq_lvl_q <= 1'b0;
            lo_q <= 8'h00;
        end else begin
            rd_st_q <= io_rd && io_addr == ADDR_REPORT;
            lo_q <= io_rdata[7:0];
            if (io_wr && io_addr == ADDR_REPORT) begin
                bsy_q <= 1'b1;
            end else if (rd_st_q) begin
                bsy_q <= io_rdata[ST_BUSY];
            end
            if (io_wr && io_word && io_addr == ADDR_SETUP) begin
                dma_en_q <= io_wdata[CFG_DMA_EN];
                irq_en_q <= io_wdata[CFG_IRQ_EN];
                irq_lvl_q <= io_wdata[CFG_IRQ_LVL];
            end
        end
    end
    sequence st_word_rd;
        io_rd && io_word && io_addr == ADDR_REPORT;
    endsequence
    sequence st_byte_rd;
        io_rd && !io_word && io_addr == ADDR_REPORT;
    endsequence
    a_rdata_quiet: assert property (io_rdata != 16'h0000 |-> $past(io_rd))
        else $error("read data outside read answer cycle");
    a_setup_revision: assert property (io_rd && io_word && io_addr == ADDR_SETUP |=> io_rdata[7:0] == {4'h0, EC_LEVEL})
        else $error("setup low byte not revision");
    a_setup_byte_zero: assert property (io_rd && !io_word && io_addr == ADDR_SETUP |=> io_rdata == 16'h0000)
        else $error("setup byte read answered");
    a_dma_chan_gate: assert property (dma_req |-> dma_chan != 3'h2 && dma_chan != 3'h4)
        else $error("dma request on channel two or four");
    a_dma_needs_en: assert property (dma_req |-> dma_en_q || $past(dma_en_q))
        else $error("dma request while disabled");
    a_irq_one_line: assert property (!(irq_l11 && irq_l12))
        else $error("both interrupt lines high");
    a_irq_needs_en: assert property ((irq_l11 || irq_l12) |-> irq_en_q || $past(irq_en_q))
        else $error("interrupt while disabled");
    a_irq_level_pick: assert property (irq_l12 |-> irq_lvl_q || $past(irq_lvl_q))
        else $error("interrupt on wrong level");
    a_byte_read_ack: assert property (st_byte_rd |=> !irq_l11 && !irq_l12)
        else $error("byte status read left interrupt up");
    a_word_read_keeps: assert property ((irq_l11 || irq_l12) ##0 st_word_rd |=> irq_l11 || irq_l12)
        else $error("word status read dropped interrupt");
    a_ack_pair_echo: assert property (st_word_rd ##1 st_byte_rd |=> io_rdata[7:0] == lo_q)
        else $error("acknowledge byte differs from word low byte");
    a_burst_legal: assert property (io_wr && io_addr == ADDR_BURST |-> !io_wdata[7] && io_wdata[0] && io_wdata[3:1] <= 3'h1)
        else $error("illegal burst setting written");
    a_no_write_busy: assert property (io_wr && (io_addr == ADDR_REPORT || io_addr == ADDR_STACK) |-> !bsy_q)
        else $error("command or stack written while busy");
    a_tag_range: assert property (io_wr && io_addr == ADDR_REPORT |-> io_wdata[4:0] <= (io_wdata[15:13] == 3'h0 ? 5'h0f : 5'h10))
        else $error("command tag out of range");
    a_word_only: assert property (io_wr && (io_addr == ADDR_REPORT || io_addr == ADDR_STACK) |-> io_word)
        else $error("byte write to command or stack");
endmodule

// [dv/scsi_adapter_host_register_port_tb_top.sv]
// Bench joining the host and adapter ends across the I/O channel
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module scsi_adapter_host_register_port_tb_top;
    import scsi_port_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic done = 1'b0;
    logic done_scsi = 1'b0;
    logic [7:0] done_code = 8'h00;
    logic [4:0] done_tag = 5'h00;
    logic [15:0] done_ext = 16'h0000;
    logic dma_want = 1'b0;
    logic init_start, cmd_valid, cmd_reserved, irq_seen, dma_req_h;
    logic [3:0] cmd_op, cmd_count;
    logic [4:0] cmd_tag;
    logic [127:0] cmd_stack;
    logic [2:0] burst_code;
    logic [31:0] sw_rdata;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int ncmd = 0;
    int stored = 0;
    scsi_io_if io_bus();
    // Arbitrary revision level
    scsi_port_dev #(.EC_LEVEL(4'h3)) scsi_port_dev_i (.clk_in(clk_in), .rstn_in(rstn_in), .io(io_bus),
        .init_start_out(init_start), .cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op),
        .cmd_reserved_out(cmd_reserved), .cmd_count_out(cmd_count), .cmd_tag_out(cmd_tag),
        .cmd_stack_out(cmd_stack), .burst_code_out(burst_code), .done_in(done), .done_scsi_in(done_scsi),
        .done_code_in(done_code), .done_tag_in(done_tag), .done_ext_in(done_ext), .done_aux_we_in(1'b0),
        .done_aux_in(16'h0000), .dma_want_in(dma_want));
    scsi_port_host scsi_port_host_i (.clk_in(clk_in), .rstn_in(rstn_in), .io(io_bus), .sw_addr_in(sw_addr),
        .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata),
        .irq_seen_out(irq_seen), .dma_req_out(dma_req_h));
    scsi_io_props #(.EC_LEVEL(4'h3)) scsi_io_props_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .io_addr(io_bus.io_addr), .io_wdata(io_bus.io_wdata), .io_wr(io_bus.io_wr), .io_rd(io_bus.io_rd),
        .io_word(io_bus.io_word), .io_rdata(io_bus.io_rdata), .irq_l11(io_bus.irq_l11),
        .irq_l12(io_bus.irq_l12), .dma_req(io_bus.dma_req), .dma_chan(io_bus.dma_chan));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cmd_valid === 1'b1)
            ncmd++;
        if (cyc == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk_in);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk_in);
        sw_rd <= 1'b0;
        @(posedge clk_in);
        d = sw_rdata;
    endtask
    // Channel access through the host sequencer; go: bit0 write, bit1 read, bit2 word
    task automatic io_op(input logic [15:0] a, input logic [15:0] d, input logic [2:0] go, output logic [31:0] r);
        int n;
        n = 0;
        sw_write(HREG_ADDR, {16'h0000, a});
        sw_write(HREG_WDATA, {16'h0000, d});
        sw_write(HREG_GO, {29'h0, go});
        do begin
            sw_read(HREG_RESULT, r);
            n++;
        end while (r[16] !== 1'b0 && n < 400);
        // Let a handed-off command be counted before callers look
        repeat (2) @(posedge clk_in);
    endtask
    task automatic fw_done(input logic s, input logic [7:0] c, input logic [4:0] t, input logic [15:0] x);
        @(posedge clk_in);
        done <= 1'b1;
        done_scsi <= s;
        done_code <= c;
        done_tag <= t;
        done_ext <= x;
        @(posedge clk_in);
        done <= 1'b0;
    endtask
    task automatic wait_l12(input logic lvl);
        int n;
        n = 0;
        while (io_bus.irq_l12 !== lvl && n < 60) begin
            @(posedge clk_in);
            n++;
        end
        `CHK(io_bus.irq_l12, lvl)
    endtask
    task automatic t_init();
        logic [31:0] r;
        int seen;
        seen = 0;
        repeat (20) begin
            @(posedge clk_in);
            if (init_start === 1'b1)
                seen++;
        end
        `CHK(seen, 1)
        `CHK(irq_seen, 1'b0)
        fw_done(1'b0, 8'h0f, UNEXPECTED_TAG, 16'h0000);
        io_op(ADDR_REPORT, 16'h0000, 3'h6, r);
        `CHK(r[15:0], 16'h0fdf)
        io_op(ADDR_REPORT, 16'h0000, 3'h6, r);
        `CHK(r[15:0], 16'h0f5f)
        $display("init test finished");
    endtask
    task automatic t_setup();
        logic [31:0] r;
        io_op(ADDR_SETUP, 16'hb3ff, 3'h5, r);
        io_op(ADDR_SETUP, 16'h0000, 3'h6, r);
        `CHK(r[15:0], 16'hb303)
        `CHK(io_bus.dma_chan, 3'h5)
        dma_want <= 1'b1;
        repeat (4) @(posedge clk_in);
        `CHK(dma_req_h, 1'b1)
        io_op(ADDR_SETUP, 16'h5300, 3'h5, r);
        `CHK(dma_req_h, 1'b0)
        io_op(ADDR_SETUP, 16'h0000, 3'h5, r);
        `CHK(dma_req_h, 1'b0)
        io_op(ADDR_SETUP, 16'h0000, 3'h2, r);
        `CHK(r[15:0], 16'h0000)
        io_op(ADDR_BURST, 16'h00fe, 3'h1, r);
        `CHK(burst_code, BURST_MAX_NORMAL)
        dma_want <= 1'b0;
        $display("setup test finished");
    endtask
    task automatic t_cmd();
        logic [31:0] r;
        int n0;
        for (int k = 0; k < 9; k++) begin
            io_op(ADDR_STACK, 16'(k * 16'h0202 + 16'h0001), 3'h5, r);
        end
        n0 = ncmd;
        io_op(ADDR_REPORT, 16'h0605, 3'h5, r);
        `CHK(ncmd - n0, 1)
        `CHK({cmd_op, cmd_count, cmd_tag}, 13'h00c5)
        `CHK(cmd_stack, 128'h0f0e0d0c0b0a09080706050403021110)
        io_op(ADDR_STACK, 16'haabb, 3'h5, r);
        io_op(ADDR_REPORT, 16'h9010, 3'h5, r);
        `CHK(cmd_stack[15:0], 16'hbbaa)
        stored = 1;
        $display("command test finished");
    endtask
    task automatic t_ops();
        logic [31:0] r;
        logic [4:0] t;
        int n0;
        for (int op = 0; op < 16; op++) begin
            t = (op < 2) ? 5'(op) : RECOVERY_TAG;
            io_op(ADDR_REPORT, {op[3:0], 7'h00, t}, 3'h5, r);
            `CHK(cmd_op, op[3:0])
            `CHK(cmd_reserved, (op == 2 || op == 3 || op > 9) ? 1'b1 : 1'b0)
        end
        stored = 3;
        n0 = ncmd;
        io_op(ADDR_REPORT, 16'h0010, 3'h5, r);
        `CHK(r[17], 1'b1)
        `CHK(ncmd - n0, 0)
        $display("opcode test finished");
    endtask
    task automatic t_done();
        logic [31:0] r;
        io_op(ADDR_SETUP, 16'h0300, 3'h5, r);
        fw_done(1'b1, 8'h02, 5'h05, 16'h00ab);
        wait_l12(1'b1);
        `CHK(io_bus.irq_l11, 1'b0)
        wait_l12(1'b0);
        repeat (10) @(posedge clk_in);
        sw_read(HREG_RESULT, r);
        `CHK(r[15:0], 16'h0265)
        `CHK(irq_seen, 1'b1)
        io_op(ADDR_REPORT, 16'h0000, 3'h6, r);
        `CHK(r[15:0], 16'h0225)
        io_op(ADDR_STACK, 16'h0000, 3'h6, r);
        `CHK(r[15:0], 16'h00ab)
        io_op(ADDR_SETUP, 16'h0000, 3'h5, r);
        stored = 2;
        $display("completion test finished");
    endtask
    task automatic t_queue();
        logic [31:0] r;
        int n0;
        n0 = ncmd;
        for (int k = stored; k < 16; k++) begin
            io_op(ADDR_REPORT, {11'h000, 5'(k)}, 3'h5, r);
        end
        io_op(ADDR_REPORT, 16'h1003, 3'h5, r);
        repeat (20) @(posedge clk_in);
        `CHK(ncmd - n0, 16 - stored)
        io_op(ADDR_REPORT, 16'h0000, 3'h6, r);
        `CHK(r[ST_BUSY], 1'b1)
        fw_done(1'b1, 8'h00, 5'h00, 16'h0000);
        repeat (4) @(posedge clk_in);
        `CHK(ncmd - n0, 17 - stored)
        `CHK(cmd_tag, 5'h03)
        io_op(ADDR_REPORT, 16'h0000, 3'h6, r);
        `CHK(r[ST_BUSY], 1'b0)
        $display("queue test finished");
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_init();
        t_setup();
        t_cmd();
        t_ops();
        t_done();
        t_queue();
        end_of_test();
    end
endmodule
